//--- design/bitexec_pkg.sv
// package of constants and types for the packed bit and branch execution block
package bitexec_pkg;
	localparam int unsigned data_width       = 32;
	localparam int unsigned byte_width       = 8;
	localparam int unsigned reg_index_width  = 5;
	localparam int unsigned disp_width       = 12;
	localparam int unsigned disp_shift       = 2;
	localparam int unsigned fill_count_width = 3;
	localparam int unsigned cond_index_width = 3;
	localparam int unsigned branch_delay_slots = 5;

	localparam logic [2:0] max_fill_when_taken = 3'h5;
	localparam logic [2:0] fill_count_reset    = 3'h0;
	localparam logic [31:0] pc_reset           = 32'h0000_0000;

	// multiply-unit operation select
	typedef enum logic [1:0] {
		mop_none     = 2'h0,
		mop_popcount = 2'h1,
		mop_reverse  = 2'h2
	} mult_op_type;

	// branch sequencer states
	typedef enum logic [2:0] {
		br_idle  = 3'b001,
		br_slots = 3'b010,
		br_fill  = 3'b100
	} branch_state_type;
endpackage : bitexec_pkg

//--- design/mult_issue_if.sv
// interface carrying a multiply-unit issue and its result between modules
`timescale 1ns/10ps
`default_nettype none
interface mult_issue_if;
	logic                                   issue;
	bitexec_pkg::mult_op_type               op;
	logic [bitexec_pkg::data_width-1:0]     src;
	logic [bitexec_pkg::reg_index_width-1:0] dst_index;
	logic                                   result_valid;
	logic [bitexec_pkg::data_width-1:0]     result;
	logic [bitexec_pkg::reg_index_width-1:0] result_index;

	modport issuer (
		output issue,
		output op,
		output src,
		output dst_index,
		input  result_valid,
		input  result,
		input  result_index
	);
	modport unit (
		input  issue,
		input  op,
		input  src,
		input  dst_index,
		output result_valid,
		output result,
		output result_index
	);
endinterface : mult_issue_if
`default_nettype wire

//--- design/bit_mult_unit.sv
// single-register-stage multiply-unit datapath for byte popcount and word bit reverse
`timescale 1ns/10ps
`default_nettype none
module bit_mult_unit (
	input  wire logic  clk,
	input  wire logic  reset,
	mult_issue_if.unit port
);
	localparam int unsigned lanes = bitexec_pkg::data_width / bitexec_pkg::byte_width;

	logic [bitexec_pkg::data_width-1:0] pop_word;
	logic [bitexec_pkg::data_width-1:0] rev_word;
	logic [bitexec_pkg::data_width-1:0] next_result;
	logic [bitexec_pkg::data_width-1:0] stage_word;
	logic [bitexec_pkg::reg_index_width-1:0] stage_index;
	logic stage_valid;

	// per-byte population count into the same lane
	genvar g;
	generate
		for (g = 0; g < lanes; g++) begin : lane
			logic [bitexec_pkg::byte_width-1:0] bits;
			assign bits = port.src[g*bitexec_pkg::byte_width +: bitexec_pkg::byte_width];
			assign pop_word[g*bitexec_pkg::byte_width +: bitexec_pkg::byte_width] =
				8'(bits[0]) + 8'(bits[1]) + 8'(bits[2]) + 8'(bits[3]) +
				8'(bits[4]) + 8'(bits[5]) + 8'(bits[6]) + 8'(bits[7]);
		end
		// source bit i lands at bit 31-i
		for (g = 0; g < bitexec_pkg::data_width; g++) begin : rev
			assign rev_word[bitexec_pkg::data_width-1-g] = port.src[g];
		end
	endgenerate

	assign next_result = (port.op == bitexec_pkg::mop_popcount) ? pop_word : rev_word;

	// one register stage samples the computed result and presents it
	always_ff @(posedge clk) begin
		if (reset) begin
			stage_valid <= 1'b0;
			stage_word  <= '0;
			stage_index <= '0;
		end else begin
			stage_valid <= port.issue && (port.op != bitexec_pkg::mop_none);
			stage_word  <= next_result;
			stage_index <= port.dst_index;
		end
	end

	assign port.result_valid = stage_valid;
	assign port.result       = stage_word;
	assign port.result_index = stage_index;
endmodule : bit_mult_unit
`default_nettype wire

//--- design/branch_fill_seq.sv
// counter that holds the pipeline idle for delay fill cycles after a branch
`timescale 1ns/10ps
`default_nettype none
module branch_fill_seq (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       start,
	input  wire logic       taken,
	input  wire logic [3:0] count,
	output logic            busy
);
	logic [3:0] remaining;
	logic [3:0] next_remaining;

	// taken branches stop the fill at the delay slot limit
	assign next_remaining = (taken && count > 4'(bitexec_pkg::max_fill_when_taken))
		? 4'(bitexec_pkg::max_fill_when_taken) : count;

	always_ff @(posedge clk) begin
		if (reset) begin
			remaining <= '0;
		end else if (start) begin
			remaining <= next_remaining;
		end else if (remaining != 4'h0) begin
			remaining <= remaining - 4'h1;
		end
	end

	// busy tells whether the cycle after this edge is a fill cycle, so a zero count stalls nothing
	assign busy = start ? (next_remaining != 4'h0) : (remaining > 4'h1);
endmodule : branch_fill_seq
`default_nettype wire

//--- design/bitexec_top.sv
// execution block for byte popcount, bit reverse and delay-filling branch
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - per-byte set-bit count into same lane
// - source bit i goes to bit 31-i
// - target is base plus displacement shifted two
// - fill count gives nop cycles after branch
// - nops inserted regardless of predicate
// - false predicate idles count plus one
// - taken branch caps fill at five
// - one branch per cycle only
// - register form only on b-side shift unit
// - target executes after five delay slots
module bitexec_top (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        mult_issue,
	input  wire logic [1:0]  mult_op,
	input  wire logic [31:0] mult_src,
	input  wire logic [4:0]  mult_dst_index,
	input  wire logic        branch_issue,
	input  wire logic        branch_register_form,
	input  wire logic        branch_on_b_side,
	input  wire logic [11:0] signed_displacement,
	input  wire logic [2:0]  delay_fill_count,
	input  wire logic [31:0] fetch_packet_base_address,
	input  wire logic [31:0] branch_src,
	input  wire logic [31:0] cond_value,
	input  wire logic        cond_zero_test,
	input  wire logic        cond_unconditional,
	output logic             write_enable,
	output logic [4:0]       write_index,
	output logic [31:0]      write_data,
	output logic             pc_load,
	output logic [31:0]      program_fetch_counter,
	output logic             nop_stall,
	output logic             branch_rejected
);
	mult_issue_if mult_link ();

	logic        predicate_true;
	logic        form_allowed;
	logic        branch_accept;
	logic        branch_go;
	logic [31:0] disp_ext;
	logic [31:0] target;
	logic [3:0]  fill_total;
	logic        fill_busy;
	logic [2:0]  slot_count;
	logic [31:0] pending_target;
	logic        pending_taken;
	bitexec_pkg::branch_state_type state;
	bitexec_pkg::branch_state_type next_state;

	//////////////////////////////////////////////////////////////////////
	// multiply unit issue
	assign mult_link.issue     = mult_issue && predicate_true;
	assign mult_link.op        = bitexec_pkg::mult_op_type'(mult_op);
	assign mult_link.src       = mult_src;
	assign mult_link.dst_index = mult_dst_index;

	bit_mult_unit mult_unit (
		.clk   (clk),
		.reset (reset),
		.port  (mult_link.unit)
	);

	// register the unit result onto the write port
	always_ff @(posedge clk) begin
		if (reset) begin
			write_enable <= 1'b0;
			write_index  <= '0;
			write_data   <= '0;
		end else begin
			write_enable <= mult_link.result_valid;
			write_index  <= mult_link.result_index;
			write_data   <= mult_link.result;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// predicate and branch decode
	assign predicate_true = cond_unconditional ||
		(cond_zero_test ? (cond_value == 32'h0000_0000) : (cond_value != 32'h0000_0000));
	assign form_allowed  = !branch_register_form || branch_on_b_side;
	// a new branch is only accepted while no earlier one is in flight
	assign branch_accept = branch_issue && form_allowed && (state == bitexec_pkg::br_idle);
	assign branch_go     = branch_accept && predicate_true;
	assign disp_ext      = {{(32-bitexec_pkg::disp_width){signed_displacement[11]}}, signed_displacement};
	assign target        = branch_register_form ? branch_src
		: fetch_packet_base_address + (disp_ext << bitexec_pkg::disp_shift);
	// untaken branches idle one cycle more than the fill count
	assign fill_total    = branch_go ? {1'b0, delay_fill_count}
		: 4'({1'b0, delay_fill_count}) + 4'h1;

	branch_fill_seq fill_seq (
		.clk   (clk),
		.reset (reset),
		.start (branch_accept),
		.taken (branch_go),
		.count (fill_total),
		.busy  (fill_busy)
	);

	//////////////////////////////////////////////////////////////////////
	// delay slot sequencer
	always_comb begin
		next_state = state;
		unique case (state)
			bitexec_pkg::br_idle: begin
				if (branch_go) begin
					next_state = bitexec_pkg::br_slots;
				end else if (branch_accept) begin
					next_state = bitexec_pkg::br_fill;
				end
			end
			bitexec_pkg::br_slots: begin
				if (slot_count == 3'(bitexec_pkg::branch_delay_slots - 1)) begin
					next_state = bitexec_pkg::br_fill;
				end
			end
			bitexec_pkg::br_fill: begin
				if (!fill_busy) begin
					next_state = bitexec_pkg::br_idle;
				end
			end
			default: next_state = bitexec_pkg::br_idle;
		endcase
	end

	// state, slot counter and captured target
	always_ff @(posedge clk) begin
		if (reset) begin
			state          <= bitexec_pkg::br_idle;
			slot_count     <= '0;
			pending_target <= bitexec_pkg::pc_reset;
			pending_taken  <= 1'b0;
		end else begin
			state <= next_state;
			slot_count <= (state == bitexec_pkg::br_slots) ? slot_count + 3'h1 : 3'h0;
			if (branch_accept) begin
				pending_target <= target;
				pending_taken  <= branch_go;
			end
		end
	end

	// counter takes the target on accept; pc_load pulses after the five delay slots, so the target starts in step
	always_ff @(posedge clk) begin
		if (reset) begin
			pc_load               <= 1'b0;
			program_fetch_counter <= bitexec_pkg::pc_reset;
			nop_stall             <= 1'b0;
			branch_rejected       <= 1'b0;
		end else begin
			pc_load <= (state == bitexec_pkg::br_slots) &&
				(slot_count == 3'(bitexec_pkg::branch_delay_slots - 1)) && pending_taken;
			if (branch_accept) begin
				program_fetch_counter <= target;
			end
			nop_stall       <= fill_busy;
			branch_rejected <= branch_issue && !form_allowed;
		end
	end
endmodule : bitexec_top
`default_nettype wire

//--- test/bitexec_chk.sv
// assertion checker for the bit and branch execution block
`timescale 1ns/10ps
`default_nettype none
module bitexec_chk (
	input wire logic clk, reset, mult_issue, branch_issue, branch_register_form, branch_on_b_side,
	input wire logic cond_zero_test, cond_unconditional, write_enable, pc_load, nop_stall, branch_rejected,
	input wire logic [1:0] mult_op,
	input wire logic [2:0] delay_fill_count,
	input wire logic [11:0] signed_displacement,
	input wire logic [31:0] cond_value, fetch_packet_base_address, program_fetch_counter
);
	// predicate, accepted issues and displacement target
	wire logic pred = cond_unconditional | ((|cond_value) ^ cond_zero_test);
	wire logic mok = mult_issue & pred & (mult_op != 2'h0);
	// sequencer busy window: six cycles after a taken branch, count plus one after an untaken one
	logic [3:0] hold;
	wire logic rej = branch_issue & (hold == 4'h0) & branch_register_form & !branch_on_b_side;
	wire logic acc = branch_issue & (hold == 4'h0) & !rej;
	wire logic tk = acc & pred;
	always_ff @(posedge clk) begin
		if (reset) begin
			hold <= 4'h0;
		end else if (acc) begin
			hold <= tk ? 4'h6 : 4'({1'b0, delay_fill_count}) + 4'h1;
		end else if (hold != 4'h0) begin
			hold <= hold - 4'h1;
		end
	end
	wire logic [31:0] tgt = fetch_packet_base_address + {{18{signed_displacement[11]}}, signed_displacement, 2'h0};
	// fill runs end on a free cycle; the load waits out five slots
	sequence s_two; nop_stall[*2] ##1 !nop_stall; endsequence
	sequence s_five; nop_stall[*5] ##1 !nop_stall; endsequence
	sequence s_eight; nop_stall[*8] ##1 !nop_stall; endsequence
	sequence s_load; !pc_load[*5] ##1 pc_load; endsequence
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_mult_write: assert property (mok |-> ##2 write_enable) else $error("no write");
	a_mult_refuse: assert property (mult_issue && !mok |-> ##2 !write_enable) else $error("bad write");
	a_disp_target: assert property (acc && !branch_register_form |=> program_fetch_counter == $past(tgt))
		else $error("bad target");
	a_side_refuse: assert property (rej |=> branch_rejected && !nop_stall) else $error("no refusal");
	a_load_slot: assert property (tk |=> s_load) else $error("load slot");
	a_no_load: assert property (acc && !pred |=> !pc_load[*8]) else $error("untaken load");
	a_fill_two: assert property (tk && delay_fill_count == 3'h2 |=> s_two) else $error("fill two");
	a_fill_cap: assert property (tk && delay_fill_count > 3'h5 |=> s_five) else $error("fill cap");
	a_idle_plus: assert property (acc && !pred && delay_fill_count == 3'h7 |=> s_eight) else $error("idle");
endmodule : bitexec_chk
bind bitexec_top bitexec_chk chk (.*);
`default_nettype wire

//--- test/fetch_model.sv
// program fetch side: counts fill cycles and follows the counter on a load
`timescale 1ns/10ps
`default_nettype none
module fetch_model (
	input wire logic clk, clear, nop_stall, pc_load,
	input wire logic [31:0] program_fetch_counter,
	output logic [3:0] stalls,
	output logic [31:0] fetch_pc
);
	// fetch holds during fill cycles and restarts at the counter on a load
	always_ff @(posedge clk) begin
		stalls <= clear ? 4'h0 : stalls + 4'(nop_stall);
		if (pc_load)
			fetch_pc <= program_fetch_counter;
	end
endmodule : fetch_model
`default_nettype wire

//--- test/bitexec_top_test.sv
// self-checking bench for the bit and branch execution block
`timescale 1ns/10ps
`default_nettype none
module bitexec_top_test;
	logic clk = 1'b0, reset = 1'b1, clear = 1'b1, mult_issue = 1'b0, branch_issue = 1'b0, cond_zero_test = 1'b0;
	logic branch_register_form = 1'b0, branch_on_b_side = 1'b0, cond_unconditional = 1'b1;
	logic [1:0] mult_op = 2'h0;
	logic [2:0] delay_fill_count = 3'h0;
	logic [4:0] mult_dst_index = 5'h0, write_index;
	logic [11:0] signed_displacement = 12'h0;
	logic [31:0] mult_src = 32'h0, cond_value = 32'h0, fetch_packet_base_address = 32'h0100_2000;
	logic [31:0] branch_src = 32'h0100_f000, write_data, program_fetch_counter, fetch_pc;
	logic [3:0] stalls;
	logic write_enable, pc_load, nop_stall, branch_rejected;
	int bad_count = 0;
	int tests_run = 0;
	always #50 clk = ~clk;
	bitexec_top dut (.*);
	fetch_model fetch (.*);
	// move just past the next rising edge
	task automatic step;
		@(posedge clk);
		#1;
	endtask : step
	task automatic chk(input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic issue(input logic [1:0] op, input logic [31:0] src);
		mult_issue = 1'b1;
		mult_op = op;
		mult_src = src;
		mult_dst_index = mult_dst_index + 5'h1;
		step;
	endtask : issue
	// back-to-back multiply ops, refusals, zero-test predicate
	task automatic t_mult;
		issue(2'h1, 32'h9e52_6e30);
		issue(2'h2, 32'ha6e2_c179);
		chk(write_enable, 32'h1);
		chk(write_index, 32'h1);
		chk(write_data, 32'h0503_0502);
		cond_unconditional = 1'b0;
		cond_value = 32'h1;
		cond_zero_test = 1'b1;
		issue(2'h1, 32'hffff_ffff);
		chk(write_data, 32'h9e83_4765);
		cond_value = 32'h0;
		issue(2'h0, 32'hffff_ffff);
		chk(write_enable, 32'h0);
		issue(2'h1, 32'hff01_8000);
		chk(write_enable, 32'h0);
		mult_issue = 1'b0;
		step;
		chk(write_data, 32'h0801_0100);
		cond_zero_test = 1'b0;
	endtask : t_mult
	// one branch: refusal pulse, load slot, fill length, new address
	task automatic branch(input logic rf, bs, p, input logic [11:0] d, input logic [2:0] n,
			input logic [31:0] pc, input logic [3:0] ns, input logic ld);
		branch_register_form = rf;
		branch_on_b_side = bs;
		cond_unconditional = p;
		signed_displacement = d;
		delay_fill_count = n;
		branch_issue = 1'b1;
		clear = 1'b1;
		step;
		branch_issue = 1'b0;
		clear = 1'b0;
		chk(branch_rejected, rf & !bs);
		repeat (5) step;
		chk(pc_load, ld);
		repeat (4) step;
		chk(stalls, ns);
		if (ld)
			chk(fetch_pc, pc);
	endtask : branch
	task automatic t_branch;
		branch(1'b0, 1'b0, 1'b1, 12'h800, 3'h2, 32'h0100_0000, 4'h2, 1'b1);
		branch(1'b0, 1'b1, 1'b1, 12'h030, 3'h7, 32'h0100_20c0, 4'h5, 1'b1);
		branch(1'b0, 1'b0, 1'b0, 12'h030, 3'h7, 32'h0, 4'h8, 1'b0);
		branch(1'b0, 1'b1, 1'b0, 12'h001, 3'h0, 32'h0, 4'h1, 1'b0);
		branch(1'b1, 1'b1, 1'b1, 12'h000, 3'h5, 32'h0100_f000, 4'h5, 1'b1);
		branch(1'b1, 1'b0, 1'b1, 12'h000, 3'h3, 32'h0, 4'h0, 1'b0);
	endtask : t_branch
	// second branch while one is in flight is dropped
	task automatic t_overlap;
		branch_register_form = 1'b0;
		branch_on_b_side = 1'b0;
		cond_unconditional = 1'b1;
		signed_displacement = 12'h010;
		delay_fill_count = 3'h0;
		branch_issue = 1'b1;
		step;
		signed_displacement = 12'h7ff;
		step;
		branch_issue = 1'b0;
		chk(program_fetch_counter, 32'h0100_2040);
		chk(nop_stall, 32'h0);
		repeat (4) step;
		chk(pc_load, 32'h1);
		step;
		chk(pc_load, 32'h0);
		step;
		chk(fetch_pc, 32'h0100_2040);
	endtask : t_overlap
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	// reset for five cycles, then the scenarios
	initial begin
		repeat (5) step;
		reset = 1'b0;
		t_mult;
		t_branch;
		t_overlap;
		test_done;
	end
endmodule : bitexec_top_test
`default_nettype wire
